// ### rtl/xtal_loop_map.vh
// Register offsets, field positions, reset values and decode constants of the crystal loop.
`ifndef XTAL_LOOP_MAP_VH
`define XTAL_LOOP_MAP_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses, one 32-bit word each)
// ----------------------------------------------------------------------
`define XLC_ADDR_W 8
`define XLC_OFS_CFG_LO 8'h00
`define XLC_OFS_CFG_HI 8'h04
`define XLC_OFS_STATUS 8'h08
`define XLC_OFS_DIVIDER 8'h0C
`define XLC_OFS_CAP 8'h10

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define XLC_CFG_RESET 64'h0000000000000000
`define XLC_WORD_ZERO 32'h00000000

// ----------------------------------------------------------------------
// Field positions inside the 64-bit serial control word
// ----------------------------------------------------------------------
`define XLC_ROM_LO 49
`define XLC_ROM_HI 51
`define XLC_CP_LO 52
`define XLC_CP_HI 53
`define XLC_POL_BIT 54
`define XLC_PD_BIT 55
`define XLC_CT_LO 56
`define XLC_CT_HI 59
`define XLC_FT_BIT 61

// ----------------------------------------------------------------------
// Status, divider and capacitance word layouts (offsets XLC_OFS_STATUS, XLC_OFS_DIVIDER, XLC_OFS_CAP)
// ----------------------------------------------------------------------
`define XLC_ST_CP_LO 0
`define XLC_ST_CP_HI 1
`define XLC_ST_ROM_LO 2
`define XLC_ST_ROM_HI 4
`define XLC_ST_OSC_PD 5
`define XLC_ST_LOOP_PD 6
`define XLC_ST_FT 7
`define XLC_ST_POL 8
`define XLC_ST_CT_LO 9
`define XLC_ST_CT_HI 12
`define XLC_DV_DIV_LO 0
`define XLC_DV_DIV_HI 11
`define XLC_DV_CP_LO 16
`define XLC_DV_CP_HI 23
`define XLC_CAP_LO 0
`define XLC_CAP_HI 11

// ----------------------------------------------------------------------
// Charge-pump current codes and values in tenths of a microamp
// ----------------------------------------------------------------------
`define XLC_CP_CODE_0 2'h0
`define XLC_CP_CODE_1 2'h1
`define XLC_CP_CODE_2 2'h2
`define XLC_CP_1U5 8'h0F
`define XLC_CP_5U 8'h32
`define XLC_CP_8U 8'h50
`define XLC_CP_24U 8'hF0

// ----------------------------------------------------------------------
// Divider ROM codes and lengths
// ----------------------------------------------------------------------
`define XLC_ROM_0 3'h0
`define XLC_ROM_1 3'h1
`define XLC_ROM_2 3'h2
`define XLC_ROM_3 3'h3
`define XLC_ROM_4 3'h4
`define XLC_ROM_5 3'h5
`define XLC_ROM_6 3'h6
`define XLC_DIV_NONE 12'h000
`define XLC_DIV_0 12'h001
`define XLC_DIV_1 12'hC00
`define XLC_DIV_2 12'hC54
`define XLC_DIV_3 12'h97E
`define XLC_DIV_4 12'h9C4
`define XLC_DIV_5 12'hFA0
`define XLC_DIV_6 12'hD2F

// ----------------------------------------------------------------------
// Coarse-tune codes and load capacitance in hundredths of a picofarad
// ----------------------------------------------------------------------
`define XLC_CT_CODE_0 4'h0
`define XLC_PF_0 12'h3E8
`define XLC_PF_1 12'h43C
`define XLC_PF_2 12'h491
`define XLC_PF_3 12'h4E5
`define XLC_PF_4 12'h53A
`define XLC_PF_5 12'h58E
`define XLC_PF_6 12'h5E2
`define XLC_PF_7 12'h637
`define XLC_PF_8 12'h68B
`define XLC_PF_9 12'h6DF
`define XLC_PF_10 12'h733
`define XLC_PF_11 12'h788
`define XLC_PF_12 12'h7DD
`define XLC_PF_13 12'h831
`define XLC_PF_14 12'h885
`define XLC_PF_15 12'h8DA

`endif

// ### rtl/xtal_divider_rom.v
// Fixed divider ROM of the crystal loop, with the oscillator power-down code.
`timescale 1ns/1ps
`default_nettype none
`include "xtal_loop_map.vh"

module xtal_divider_rom (
	input wire [2:0] sel,
	output reg [11:0] divider,
	output reg osc_powerdown
);

	// ----------------------------------------------------------------------
	// ROM lookup
	// ----------------------------------------------------------------------
	always @* begin
		osc_powerdown = 1'b0;
		case (sel)
			`XLC_ROM_0: divider = `XLC_DIV_0; // RULE3
			`XLC_ROM_1: divider = `XLC_DIV_1; // RULE3
			`XLC_ROM_2: divider = `XLC_DIV_2; // RULE3
			`XLC_ROM_3: divider = `XLC_DIV_3; // RULE3
			`XLC_ROM_4: divider = `XLC_DIV_4; // RULE3
			`XLC_ROM_5: divider = `XLC_DIV_5; // RULE3
			`XLC_ROM_6: divider = `XLC_DIV_6; // RULE3
			default: begin
				// The last code applies no divider; it stops the oscillator instead.
				divider = `XLC_DIV_NONE; // RULE4
				osc_powerdown = 1'b1; // RULE4
			end
		endcase
	end

endmodule
`default_nettype wire

// ### rtl/crystal_loop_control.v
// Crystal loop control word with its register port and registered field decode.
`timescale 1ns/1ps
`default_nettype none
`include "xtal_loop_map.vh"

// Operation
// (RULE1) Pump field picks 1.5, 5, 8, 24 uA
// (RULE2) ROM select field picks VCXO divider
// (RULE3) ROM codes map to fixed divider lengths
// (RULE4) Code seven powers oscillator down, no divider
// (RULE5) Fine tune active only while bit set
// (RULE6) Polarity bit selects tune voltage sense
// (RULE7) Host sets polarity for internal VCXO
// (RULE8) Loop powered down while bit set
// (RULE9) Four-bit coarse code selects load step
// (RULE10) Sixteen steps from 10.00 to 22.66 pF
// (RULE11) Host-written word drives decoded outputs
module crystal_loop_control (
	input wire clk,
	input wire reset,
	input wire [7:0] address,
	input wire [31:0] write_data,
	input wire write_strobe,
	input wire read_strobe,
	output reg [31:0] read_data,
	output reg [1:0] xtal_pump_current_sel,
	output reg [7:0] pump_current_tenth_ua,
	output reg [2:0] xtal_divider_rom_sel,
	output reg [11:0] vcxo_divider,
	output reg xtal_osc_powerdown,
	output reg fine_tune_enable,
	output reg tune_polarity_falling,
	output reg xtal_loop_powerdown,
	output reg [3:0] xtal_coarse_tune_code,
	output reg [11:0] coarse_cap_centi_pf,
	output reg config_update
);

	// ----------------------------------------------------------------------
	// Decode functions
	// ----------------------------------------------------------------------

	// Pump current in tenths of a microamp, so 1.5 uA stays exact.
	function [7:0] pump_value;
		input [1:0] code;
		begin
			case (code)
				`XLC_CP_CODE_0: pump_value = `XLC_CP_1U5;
				`XLC_CP_CODE_1: pump_value = `XLC_CP_5U;
				`XLC_CP_CODE_2: pump_value = `XLC_CP_8U;
				default: pump_value = `XLC_CP_24U;
			endcase
		end
	endfunction

	// Load capacitance in hundredths of a picofarad.
	function [11:0] cap_value;
		input [3:0] code;
		begin
			case (code)
				4'h0: cap_value = `XLC_PF_0;
				4'h1: cap_value = `XLC_PF_1;
				4'h2: cap_value = `XLC_PF_2;
				4'h3: cap_value = `XLC_PF_3;
				4'h4: cap_value = `XLC_PF_4;
				4'h5: cap_value = `XLC_PF_5;
				4'h6: cap_value = `XLC_PF_6;
				4'h7: cap_value = `XLC_PF_7;
				4'h8: cap_value = `XLC_PF_8;
				4'h9: cap_value = `XLC_PF_9;
				4'hA: cap_value = `XLC_PF_10;
				4'hB: cap_value = `XLC_PF_11;
				4'hC: cap_value = `XLC_PF_12;
				4'hD: cap_value = `XLC_PF_13;
				4'hE: cap_value = `XLC_PF_14;
				default: cap_value = `XLC_PF_15;
			endcase
		end
	endfunction

	// ----------------------------------------------------------------------
	// Serial control word
	// ----------------------------------------------------------------------
	reg [63:0] control_word;
	reg word_written;
	wire write_lo;
	wire write_hi;

	assign write_lo = write_strobe && (address == `XLC_OFS_CFG_LO);
	assign write_hi = write_strobe && (address == `XLC_OFS_CFG_HI);

	// The word is held in two halves; every crystal-loop field lives in the
	// upper half, so a single upper write is enough to retune the loop.
	always @(posedge clk) begin
		if (reset) begin
			control_word <= `XLC_CFG_RESET;
			word_written <= 1'b0;
		end else begin
			if (write_lo) begin
				control_word[31:0] <= write_data;
			end
			if (write_hi) begin
				control_word[63:32] <= write_data; // RULE11
			end
			word_written <= write_lo || write_hi;
		end
	end

	// ----------------------------------------------------------------------
	// Field extraction
	// ----------------------------------------------------------------------
	wire [1:0] pump_field;
	wire [2:0] rom_field;
	wire [3:0] coarse_field;
	wire [11:0] rom_divider;
	wire rom_osc_powerdown;

	assign pump_field = control_word[`XLC_CP_HI:`XLC_CP_LO]; // RULE1
	assign rom_field = control_word[`XLC_ROM_HI:`XLC_ROM_LO]; // RULE2
	assign coarse_field = control_word[`XLC_CT_HI:`XLC_CT_LO]; // RULE9

	xtal_divider_rom divider_rom (
		.sel(rom_field),
		.divider(rom_divider),
		.osc_powerdown(rom_osc_powerdown)
	);

	// ----------------------------------------------------------------------
	// Registered decode outputs
	// ----------------------------------------------------------------------

	// Outputs follow the word one cycle after it is stored. The decode is
	// registered so that no output glitches while the ROM settles.
	always @(posedge clk) begin
		if (reset) begin
			xtal_pump_current_sel <= `XLC_CP_CODE_0;
			pump_current_tenth_ua <= `XLC_CP_1U5;
			xtal_divider_rom_sel <= `XLC_ROM_0;
			vcxo_divider <= `XLC_DIV_0;
			xtal_osc_powerdown <= 1'b0;
			fine_tune_enable <= 1'b0;
			tune_polarity_falling <= 1'b0;
			xtal_loop_powerdown <= 1'b0;
			xtal_coarse_tune_code <= `XLC_CT_CODE_0;
			coarse_cap_centi_pf <= `XLC_PF_0;
			config_update <= 1'b0;
		end else begin
			xtal_pump_current_sel <= pump_field; // RULE1
			pump_current_tenth_ua <= pump_value(pump_field); // RULE1
			xtal_divider_rom_sel <= rom_field; // RULE2
			vcxo_divider <= rom_divider; // RULE3
			xtal_osc_powerdown <= rom_osc_powerdown; // RULE4
			fine_tune_enable <= control_word[`XLC_FT_BIT]; // RULE5
			// The sense is only carried out; the host is expected to set it
			// whenever the on-chip oscillator is in use.
			tune_polarity_falling <= control_word[`XLC_POL_BIT]; // RULE6
			xtal_loop_powerdown <= control_word[`XLC_PD_BIT]; // RULE8
			xtal_coarse_tune_code <= coarse_field; // RULE9
			coarse_cap_centi_pf <= cap_value(coarse_field); // RULE10
			config_update <= word_written; // RULE11
		end
	end

	// ----------------------------------------------------------------------
	// Readback words
	// ----------------------------------------------------------------------
	reg [31:0] status_word;
	reg [31:0] divider_word;
	reg [31:0] cap_word;

	always @* begin
		status_word = `XLC_WORD_ZERO;
		status_word[`XLC_ST_CP_HI:`XLC_ST_CP_LO] = xtal_pump_current_sel;
		status_word[`XLC_ST_ROM_HI:`XLC_ST_ROM_LO] = xtal_divider_rom_sel;
		status_word[`XLC_ST_OSC_PD] = xtal_osc_powerdown;
		status_word[`XLC_ST_LOOP_PD] = xtal_loop_powerdown;
		status_word[`XLC_ST_FT] = fine_tune_enable;
		status_word[`XLC_ST_POL] = tune_polarity_falling;
		status_word[`XLC_ST_CT_HI:`XLC_ST_CT_LO] = xtal_coarse_tune_code;
		divider_word = `XLC_WORD_ZERO;
		divider_word[`XLC_DV_DIV_HI:`XLC_DV_DIV_LO] = vcxo_divider;
		divider_word[`XLC_DV_CP_HI:`XLC_DV_CP_LO] = pump_current_tenth_ua;
		cap_word = `XLC_WORD_ZERO;
		cap_word[`XLC_CAP_HI:`XLC_CAP_LO] = coarse_cap_centi_pf;
	end

	// ----------------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------------

	// Read data stand for exactly one cycle after the strobe and are zero
	// otherwise, so a stale value can never be mistaken for an answer.
	// Unmapped addresses answer zero.
	always @(posedge clk) begin
		if (reset) begin
			read_data <= `XLC_WORD_ZERO;
		end else if (read_strobe) begin
			case (address)
				`XLC_OFS_CFG_LO: read_data <= control_word[31:0];
				`XLC_OFS_CFG_HI: read_data <= control_word[63:32];
				`XLC_OFS_STATUS: read_data <= status_word;
				`XLC_OFS_DIVIDER: read_data <= divider_word;
				`XLC_OFS_CAP: read_data <= cap_word;
				default: read_data <= `XLC_WORD_ZERO;
			endcase
		end else begin
			read_data <= `XLC_WORD_ZERO;
		end
	end

endmodule
`default_nettype wire

// ### verif/xtal_loop_checker.sv
// Assertions on the ports of the crystal loop control block.
`timescale 1ns/1ps
`default_nettype none
module xtal_loop_checker (
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] address,
	input wire logic [31:0] write_data,
	input wire logic write_strobe,
	input wire logic read_strobe,
	input wire logic [31:0] read_data,
	input wire logic [1:0] xtal_pump_current_sel,
	input wire logic [7:0] pump_current_tenth_ua,
	input wire logic [2:0] xtal_divider_rom_sel,
	input wire logic [11:0] vcxo_divider,
	input wire logic xtal_osc_powerdown,
	input wire logic fine_tune_enable,
	input wire logic tune_polarity_falling,
	input wire logic xtal_loop_powerdown,
	input wire logic [3:0] xtal_coarse_tune_code,
	input wire logic [11:0] coarse_cap_centi_pf,
	input wire logic config_update
);
	localparam logic [11:0] div_t [8] = '{12'h001, 12'hC00, 12'hC54, 12'h97E,
		12'h9C4, 12'hFA0, 12'hD2F, 12'h000};
	default clocking @(posedge clk);
	endclocking
	default disable iff (reset);
	sequence s_hi_write;
		write_strobe && address == 8'h04;
	endsequence
	sequence s_taken;
		##2 config_update;
	endsequence
	a_update_taken: assert property (s_hi_write |-> s_taken)
		else $error("no update pulse two cycles after a write");
	a_update_cause: assert property (config_update |->
		$past(write_strobe && (address == 8'h00 || address == 8'h04), 2))
		else $error("update pulse without a write");
	a_field_copy: assert property (s_hi_write |-> ##2
		{xtal_pump_current_sel, xtal_divider_rom_sel, fine_tune_enable, tune_polarity_falling,
		xtal_loop_powerdown, xtal_coarse_tune_code}
		== $past({write_data[21:17], write_data[29], write_data[22], write_data[23],
		write_data[27:24]}, 2))
		else $error("decoded fields differ from written word");
	a_pump_map: assert property (pump_current_tenth_ua == (
		xtal_pump_current_sel == 2'h0 ? 8'h0F : xtal_pump_current_sel == 2'h1 ? 8'h32 :
		xtal_pump_current_sel == 2'h2 ? 8'h50 : 8'hF0))
		else $error("pump current does not match its code");
	a_divider_map: assert property (vcxo_divider == div_t[xtal_divider_rom_sel])
		else $error("divider does not match its code");
	a_osc_off: assert property (xtal_osc_powerdown == (xtal_divider_rom_sel == 3'h7))
		else $error("oscillator power-down does not follow code seven");
	a_cap_ends: assert property (xtal_coarse_tune_code inside {4'h0, 4'hF} |->
		coarse_cap_centi_pf == (xtal_coarse_tune_code[0] ? 12'h8DA : 12'h3E8))
		else $error("capacitance end value wrong");
	a_read_idle: assert property (!$past(read_strobe) |-> read_data == 32'h00000000)
		else $error("read data not zero outside a read answer");
	// The first edge after reset is skipped: outputs legally jump to their reset values there.
	a_outputs_hold: assert property (!config_update && !$past(reset) |->
		$stable({xtal_pump_current_sel, xtal_divider_rom_sel, xtal_coarse_tune_code,
		vcxo_divider, fine_tune_enable, tune_polarity_falling, xtal_loop_powerdown}))
		else $error("decoded outputs moved without an update");
endmodule
bind crystal_loop_control xtal_loop_checker i_chk (.clk(clk), .reset(reset), .address(address),
	.write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe),
	.read_data(read_data), .xtal_pump_current_sel(xtal_pump_current_sel),
	.pump_current_tenth_ua(pump_current_tenth_ua), .xtal_divider_rom_sel(xtal_divider_rom_sel),
	.vcxo_divider(vcxo_divider), .xtal_osc_powerdown(xtal_osc_powerdown),
	.fine_tune_enable(fine_tune_enable), .tune_polarity_falling(tune_polarity_falling),
	.xtal_loop_powerdown(xtal_loop_powerdown), .xtal_coarse_tune_code(xtal_coarse_tune_code),
	.coarse_cap_centi_pf(coarse_cap_centi_pf), .config_update(config_update));
`default_nettype wire

// ### verif/host_bus_model.sv
// Register bus master standing in for the host that programs the control word.
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
	input wire logic clk,
	output logic [7:0] address,
	output logic [31:0] write_data,
	output logic write_strobe,
	output logic read_strobe
);
	initial begin
		address = 8'h00;
		write_data = 32'h00000000;
		write_strobe = 1'b0;
		read_strobe = 1'b0;
	end
	// Each call starts just after a rising edge and returns just after the next one.
	task wr(input logic [7:0] a, input logic [31:0] d);
		address <= a;
		write_data <= d;
		write_strobe <= 1'b1;
		read_strobe <= 1'b0;
		@(posedge clk);
	endtask
	task rd(input logic [7:0] a);
		address <= a;
		write_strobe <= 1'b0;
		read_strobe <= 1'b1;
		@(posedge clk);
	endtask
	// Released lines are inverted so that a design relying on stale values is caught.
	task idle(input int n);
		address <= ~address;
		write_data <= ~write_data;
		write_strobe <= 1'b0;
		read_strobe <= 1'b0;
		repeat (n) @(posedge clk);
	endtask
endmodule
`default_nettype wire

// ### verif/crystal_loop_control_bench.sv
// Self-checking bench for the crystal loop control block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((e) !== (g)) begin err_total++; \
	$display("MISMATCH %s exp %h got %h", n, e, g); end end
module crystal_loop_control_bench;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] address;
	logic [31:0] write_data, read_data, d, er, lo_w;
	logic [31:0] hi_w = 32'h00000000;
	logic write_strobe, read_strobe, osc, ft, pol, lpd, upd;
	logic rd_pend = 1'b0;
	logic [1:0] cp;
	logic [7:0] ua;
	logic [2:0] rom;
	logic [3:0] ct;
	logic [11:0] div, cap;
	logic [44:0] ed;
	wire [44:0] dec = {cp, ua, rom, div, osc, ft, pol, lpd, ct, cap};
	int err_total = 0;
	int checks_done = 0;
	logic [44:0] q_dec[$];
	logic [31:0] q_rd[$];
	logic [7:0] ua_t [4] = '{8'h0F, 8'h32, 8'h50, 8'hF0};
	logic [11:0] div_t [8] = '{12'h001, 12'hC00, 12'hC54, 12'h97E, 12'h9C4, 12'hFA0, 12'hD2F,
		12'h000};
	logic [11:0] cap_t [16] = '{12'h3E8, 12'h43C, 12'h491, 12'h4E5, 12'h53A, 12'h58E, 12'h5E2,
		12'h637, 12'h68B, 12'h6DF, 12'h733, 12'h788, 12'h7DD, 12'h831, 12'h885, 12'h8DA};
	logic [7:0] a_t [4] = '{8'h08, 8'h0C, 8'h10, 8'h14};
	always #5 clk = ~clk;
	host_bus_model i_host (.clk(clk), .address(address), .write_data(write_data),
		.write_strobe(write_strobe), .read_strobe(read_strobe));
	crystal_loop_control i_dut (.clk(clk), .reset(reset), .address(address),
		.write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe),
		.read_data(read_data), .xtal_pump_current_sel(cp), .pump_current_tenth_ua(ua),
		.xtal_divider_rom_sel(rom), .vcxo_divider(div), .xtal_osc_powerdown(osc),
		.fine_tune_enable(ft), .tune_polarity_falling(pol), .xtal_loop_powerdown(lpd),
		.xtal_coarse_tune_code(ct), .coarse_cap_centi_pf(cap), .config_update(upd));
	function automatic logic [44:0] exp_dec(input logic [31:0] w);
		return {w[21:20], ua_t[w[21:20]], w[19:17], div_t[w[19:17]], w[19:17] == 3'h7, w[29],
			w[22], w[23], w[27:24], cap_t[w[27:24]]};
	endfunction
	task automatic wr(input logic [7:0] a, input logic [31:0] w);
		// Either half of the word raises the update pulse; the fields all sit in the upper half.
		if (a == 8'h04) hi_w = w;
		if (a == 8'h00 || a == 8'h04) q_dec.push_back(exp_dec(hi_w));
		i_host.wr(a, w);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		q_rd.push_back(e);
		i_host.rd(a);
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ----
	// Result watcher
	// ----
	always @(posedge clk) begin
		rd_pend <= read_strobe && !reset;
		if (rd_pend) begin
			er = q_rd.pop_front();
			`CHK("read_data", er, read_data)
		end
		if (upd === 1'b1 && q_dec.size() == 0) `CHK("config_update", 1'b0, upd)
		else if (upd === 1'b1) begin
			ed = q_dec.pop_front();
			`CHK("decode", ed, dec)
		end
	end
	// ----
	// Tests
	// ----
	initial begin
		void'($urandom(43));
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		`CHK("reset decode", exp_dec(32'h0), dec)
		rd(8'h00, 32'h0);
		rd(8'h04, 32'h0);
		rd(8'h0C, 32'h000F0001);
		rd(8'h10, 32'h000003E8);
		i_host.idle(3);
		$display("test reset values done");
		for (int i = 0; i < 16; i++) begin
			d = $urandom;
			d[27:17] = {i[3:0], d[23:22], i[1:0], i[2:0]};
			wr(8'h04, d);
			rd(8'h04, d);
		end
		d[22] = 1'b1;
		wr(8'h04, d);
		for (int k = 0; k < 4; k++) wr(a_t[k], $urandom);
		rd(8'h04, d);
		rd(8'h08, {19'h0, d[27:24], d[22], d[29], d[23], d[19:17] == 3'h7, d[19:17], d[21:20]});
		rd(8'h0C, {8'h0, ua_t[d[21:20]], 4'h0, div_t[d[19:17]]});
		rd(8'h10, {20'h0, cap_t[d[27:24]]});
		rd(8'h14, 32'h0);
		lo_w = $urandom;
		wr(8'h00, lo_w);
		rd(8'h00, lo_w);
		rd(8'h04, d);
		i_host.idle(3);
		$display("test codes and refused writes done");
		reset <= 1'b1;
		hi_w = 32'h00000000;
		@(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		`CHK("mid reset decode", exp_dec(32'h0), dec)
		rd(8'h04, 32'h0);
		rd(8'h00, 32'h0);
		i_host.idle(3);
		`CHK("open updates", 0, q_dec.size())
		`CHK("open reads", 0, q_rd.size())
		$display("test mid-run reset done");
		print_verdict;
	end
	// The tests need about 70 cycles; the watchdog allows far more.
	initial begin
		repeat (2000) @(posedge clk);
		err_total++;
		print_verdict;
	end
endmodule
`default_nettype wire
